// *** rtl/ces_od_regs.sv ***
// object dictionary: error register, vendor fault word, tpdo maps
// assumes an upstream sdo engine gives index/subindex strobes
`timescale 1ns/1ps
`include "ces_defs.svh"
module ces_od_regs (
    input  wire logic              clk,          // 250 mhz clock
    input  wire logic              reset_n,      // async reset, low
    input  wire logic              dual_axis,    // variant strap
    input  wire logic              boot_done,    // boot finished pulse
    input  wire logic              obj_valid,    // access strobe
    input  wire logic              obj_write,    // 1 write, 0 read
    input  wire logic [15:0]       obj_index,    // object index
    input  wire logic [7:0]        obj_sub,      // subindex
    input  wire ces_pkg::ces_word_t obj_wdata,   // write data
    input  wire logic [5:1]        err_class,    // current..profile
    input  wire logic [1:0]        tilt_cross,   // x, y cross tilt
    input  wire logic [1:0]        tilt_range,   // x, y out of range
    input  wire logic              temp_low,     // below limit
    input  wire logic              temp_high,    // above limit
    input  wire logic              power_fault,  // supply fault now
    input  wire logic [4:0]        mem_faults,   // eeprom..handler
    output logic                   obj_ack,      // answer pulse
    output logic                   obj_abort,    // refused access
    output ces_pkg::ces_word_t     obj_rdata,    // read data or abort code
    output logic                   store_req,    // commit to store pulse
    output logic [7:0]             err_reg,      // error register
    output ces_pkg::ces_word_t     vendor_word,  // vendor fault word
    output logic [15:0]            evt2_time,    // tpdo2 event timer ms
    output ces_pkg::ces_nmt_t      nmt_state     // nmt state
);
    import ces_pkg::*;
    ////////////////////////////////////////////////////////////////
    // declarations
    logic [15:0] evt2_q, evt2_d;
    ces_word_t   start_q, start_d;
    ces_nmt_t    nmt_d;
    logic        pwr_mem_q, pwr_mem_d;
    logic [7:0]  err_d;
    ces_word_t   vf_d;
    logic        ack_d, abort_d, store_d;
    ces_word_t   rd_d;
    logic        pend_q, pend_d;
    logic        pend_sel_q, pend_sel_d;
    logic [7:0]  m1_cnt_rst;
    logic        m1_wr, m2_wr, hit_m1, hit_m2, boot_fix;
    ces_word_t   m1_rd, m2_rd;
    logic        dual_q;
    ////////////////////////////////////////////////////////////////
    // variant is caught after release, not in reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) dual_q <= 1'b0;
        else dual_q <= dual_axis;
    end
    // dual variant count, written once as boot completes; an m1_wr in that cycle wins and the count is not fixed up
    assign m1_cnt_rst = `CES_MAP1_CNT_TWO;
    assign boot_fix   = boot_done && dual_q && nmt_state == CES_NMT_BOOT;
    assign hit_m1 = obj_index == `CES_IDX_MAP1 && obj_sub <= 8'(`CES_MAP_ENTRIES);
    assign hit_m2 = obj_index == `CES_IDX_MAP2 && obj_sub <= 8'(`CES_MAP_ENTRIES);
    // no table write while a map read is pending, strobe is ignored then
    assign m1_wr  = obj_valid && !pend_q && obj_write && hit_m1;
    assign m2_wr  = obj_valid && !pend_q && obj_write && hit_m2;
    // first tpdo table; count fixed up from strap below
    ces_map_table #(
        .CNT_RST (`CES_MAP1_CNT_ONE),
        .E1_RST  (`CES_MAP1_E1_RST),
        .E2_RST  (`CES_MAP1_E2_RST),
        .E3_RST  (`CES_ZERO32)
    ) u_map1 (
        .clk     (clk),
        .reset_n (reset_n),
        .wr_en   (m1_wr || boot_fix),
        .wr_sub  (boot_fix && !m1_wr ? `CES_SUB_COUNT : obj_sub),
        .wr_data (boot_fix && !m1_wr ? {24'h000000, m1_cnt_rst} : obj_wdata),
        .rd_sub  (obj_sub),
        .rd_data (m1_rd)
    );
    // second tpdo table, disabled by default
    ces_map_table #(
        .CNT_RST (`CES_MAP2_CNT_RST),
        .E1_RST  (`CES_MAP2_E1_RST),
        .E2_RST  (`CES_MAP2_E2_RST),
        .E3_RST  (`CES_MAP2_E3_RST)
    ) u_map2 (
        .clk     (clk),
        .reset_n (reset_n),
        .wr_en   (m2_wr),
        .wr_sub  (obj_sub),
        .wr_data (obj_wdata),
        .rd_sub  (obj_sub),
        .rd_data (m2_rd)
    );
    ////////////////////////////////////////////////////////////////
    // status words from fault inputs
    always_comb begin
        pwr_mem_d = pwr_mem_q | power_fault;
        vf_d = `CES_ZERO32;                                // bits 13-31 unused
        vf_d[1:0] = tilt_cross;
        vf_d[3:2] = tilt_range;
        vf_d[4] = temp_low;
        vf_d[5] = temp_high;
        vf_d[`CES_VF_PWR_NOW] = power_fault;
        vf_d[`CES_VF_PWR_MEM] = pwr_mem_d;
        vf_d[`CES_VF_USED-1:8] = mem_faults;
        err_d = 8'h00;
        err_d[`CES_ERR_PROF:`CES_ERR_CUR] = err_class;
        err_d[`CES_ERR_MFR] = |vf_d;
        err_d[`CES_ERR_RSVD] = 1'b0;
        err_d[`CES_ERR_GEN] = |err_d[7:1];
    end
    ////////////////////////////////////////////////////////////////
    // object decode, one access per strobe, answer after one cycle, map table reads after two
    always_comb begin
        evt2_d     = evt2_q;
        start_d    = start_q;
        ack_d      = 1'b0;
        abort_d    = 1'b0;
        store_d    = 1'b0;
        rd_d       = `CES_ZERO32;
        pend_d     = 1'b0;
        pend_sel_d = 1'b0;
        if (pend_q) begin
            // table read data is registered, answer one cycle later
            ack_d = 1'b1;
            rd_d  = pend_sel_q ? m2_rd : m1_rd;
        end else if (obj_valid) begin
            ack_d = 1'b1;
            unique case (obj_index)
                `CES_IDX_ERR_REG: begin
                    if (obj_write || obj_sub != 8'h00) abort_d = 1'b1;
                    else rd_d = {24'h000000, err_reg};
                end
                `CES_IDX_VND_WORD: begin
                    if (obj_write || obj_sub != 8'h00) abort_d = 1'b1;
                    else rd_d = vendor_word;
                end
                `CES_IDX_EVT2: begin
                    if (obj_sub != `CES_SUB_EVT) abort_d = 1'b1;
                    else if (obj_write) evt2_d = obj_wdata[15:0];
                    else rd_d = {16'h0000, evt2_q};
                end
                `CES_IDX_STARTUP: begin
                    if (obj_sub != 8'h00) abort_d = 1'b1;
                    else if (obj_write) start_d = obj_wdata;
                    else rd_d = start_q;
                end
                `CES_IDX_SAVE: begin
                    // commit request goes to nonvolatile store
                    if (obj_write) store_d = 1'b1;
                    else abort_d = 1'b1;
                end
                `CES_IDX_MAP1, `CES_IDX_MAP2: begin
                    if (!(hit_m1 || hit_m2)) abort_d = 1'b1;
                    else if (!obj_write) begin
                        ack_d      = 1'b0;
                        pend_d     = 1'b1;
                        pend_sel_d = hit_m2;
                    end
                end
                default: abort_d = 1'b1;
            endcase
            if (abort_d) begin
                evt2_d  = evt2_q;
                start_d = start_q;
                rd_d    = obj_write ? `CES_ABORT_RO : `CES_ABORT_NOOBJ;
            end
        end
    end
    // nmt state after boot
    always_comb begin
        nmt_d = nmt_state;
        if (boot_done && nmt_state == CES_NMT_BOOT)
            nmt_d = start_q == `CES_START_PREOP ? CES_NMT_PREOP : CES_NMT_OP;
    end
    ////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            evt2_q      <= `CES_EVT2_RST;
            start_q     <= `CES_START_OP;
            pwr_mem_q   <= 1'b0;
            pend_q      <= 1'b0;
            pend_sel_q  <= 1'b0;
            obj_ack     <= 1'b0;
            obj_abort   <= 1'b0;
            obj_rdata   <= `CES_ZERO32;
            store_req   <= 1'b0;
            err_reg     <= 8'h00;
            vendor_word <= `CES_ZERO32;
            evt2_time   <= `CES_EVT2_RST;
            nmt_state   <= CES_NMT_BOOT;
        end else begin
            evt2_q      <= evt2_d;
            start_q     <= start_d;
            pwr_mem_q   <= pwr_mem_d;
            pend_q      <= pend_d;
            pend_sel_q  <= pend_sel_d;
            obj_ack     <= ack_d;
            obj_abort   <= abort_d;
            obj_rdata   <= rd_d;
            store_req   <= store_d;
            err_reg     <= err_d;
            vendor_word <= vf_d;
            evt2_time   <= evt2_d;
            nmt_state   <= nmt_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    // checks
    property p_gen_bit;
        @(posedge clk) disable iff (!reset_n) err_reg[`CES_ERR_GEN] == (|err_reg[7:1]);
    endproperty
    a_gen_bit: assert property (p_gen_bit) else $error("generic bit wrong");
    property p_rsvd_bit;
        @(posedge clk) disable iff (!reset_n) err_reg[`CES_ERR_RSVD] == 1'b0;
    endproperty
    a_rsvd_bit: assert property (p_rsvd_bit) else $error("bit 6 set");
    property p_mfr_bit;
        @(posedge clk) disable iff (!reset_n) err_reg[`CES_ERR_MFR] == (|vendor_word);
    endproperty
    a_mfr_bit: assert property (p_mfr_bit) else $error("mfr bit wrong");
    property p_pwr_mem;
        @(posedge clk) disable iff (!reset_n) vendor_word[`CES_VF_PWR_MEM] |=> vendor_word[`CES_VF_PWR_MEM];
    endproperty
    a_pwr_mem: assert property (p_pwr_mem) else $error("power memory lost");
    property p_pwr_set;
        @(posedge clk) disable iff (!reset_n) power_fault |=> vendor_word[`CES_VF_PWR_NOW] && vendor_word[`CES_VF_PWR_MEM];
    endproperty
    a_pwr_set: assert property (p_pwr_set) else $error("power fault missed");
    property p_unused;
        @(posedge clk) disable iff (!reset_n) vendor_word[31:`CES_VF_USED] == 19'h00000;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bits set");
    property p_tilt;
        @(posedge clk) disable iff (!reset_n) 1'b1 |=> vendor_word[3:0] == {$past(tilt_range), $past(tilt_cross)};
    endproperty
    a_tilt: assert property (p_tilt) else $error("tilt bits wrong");
    property p_class;
        @(posedge clk) disable iff (!reset_n) 1'b1 |=> err_reg[5:1] == $past(err_class);
    endproperty
    a_class: assert property (p_class) else $error("class bits wrong");
    property p_boot;
        @(posedge clk) disable iff (!reset_n)
            boot_done && nmt_state == CES_NMT_BOOT && start_q == `CES_START_PREOP |=> nmt_state == CES_NMT_PREOP;
    endproperty
    a_boot: assert property (p_boot) else $error("not preop after boot");
    property p_unmapped;
        @(posedge clk) disable iff (!reset_n)
            obj_valid && !pend_q && obj_index == 16'h2000 |=> obj_ack && obj_abort;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hidden object answered");
    // answer timing, abort codes, store request, boot state and remaining status fields
    property p_answer;
        @(posedge clk) disable iff (!reset_n) obj_valid && !pend_q |-> ##[1:2] obj_ack;
    endproperty
    a_answer: assert property (p_answer) else $error("access not answered");
    property p_abort_code;
        @(posedge clk) disable iff (!reset_n)
            obj_abort |-> obj_ack && (obj_rdata == `CES_ABORT_RO || obj_rdata == `CES_ABORT_NOOBJ);
    endproperty
    a_abort_code: assert property (p_abort_code) else $error("abort code wrong");
    property p_map_rd;
        @(posedge clk) disable iff (!reset_n)
            obj_valid && !pend_q && !obj_write && (hit_m1 || hit_m2) |=> !obj_ack ##1 obj_ack;
    endproperty
    a_map_rd: assert property (p_map_rd) else $error("map read timing wrong");
    property p_store;
        @(posedge clk) disable iff (!reset_n)
            obj_valid && !pend_q && obj_write && obj_index == `CES_IDX_SAVE |=> store_req;
    endproperty
    a_store: assert property (p_store) else $error("store request missed");
    property p_op_boot;
        @(posedge clk) disable iff (!reset_n)
            boot_done && nmt_state == CES_NMT_BOOT && start_q != `CES_START_PREOP |=> nmt_state == CES_NMT_OP;
    endproperty
    a_op_boot: assert property (p_op_boot) else $error("not operational after boot");
    property p_temp;
        @(posedge clk) disable iff (!reset_n) 1'b1 |=> vendor_word[5:4] == {$past(temp_high), $past(temp_low)};
    endproperty
    a_temp: assert property (p_temp) else $error("temperature bits wrong");
    property p_mem;
        @(posedge clk) disable iff (!reset_n) 1'b1 |=> vendor_word[12:8] == $past(mem_faults);
    endproperty
    a_mem: assert property (p_mem) else $error("fault bits wrong");
    property p_pwr_now;
        @(posedge clk) disable iff (!reset_n) 1'b1 |=> vendor_word[`CES_VF_PWR_NOW] == $past(power_fault);
    endproperty
    a_pwr_now: assert property (p_pwr_now) else $error("power now bit wrong");
    c_abort: cover property (@(posedge clk) disable iff (!reset_n) obj_abort);
    c_map_rd: cover property (@(posedge clk) disable iff (!reset_n) pend_q ##1 obj_ack);
    c_store: cover property (@(posedge clk) disable iff (!reset_n) store_req);
    c_mfr: cover property (@(posedge clk) disable iff (!reset_n) err_reg == 8'h81);
endmodule : ces_od_regs

// *** include/ces_defs.svh ***
// constants of the error, status and tpdo mapping objects
// assumes inclusion by bare name from the package and design files
`ifndef CES_DEFS_SVH
`define CES_DEFS_SVH
`define CES_IDX_ERR_REG      16'h1001
`define CES_IDX_VND_WORD     16'h1002
`define CES_IDX_SAVE         16'h1010
`define CES_IDX_MAP1         16'h1a00
`define CES_IDX_MAP2         16'h1a01
`define CES_IDX_EVT2         16'h1801
`define CES_IDX_STARTUP      16'h1f80
`define CES_SUB_EVT          8'h05
`define CES_SUB_COUNT        8'h00
`define CES_MAP_ENTRIES      4
`define CES_EVT2_RST         16'h0064
`define CES_EVT_MS           100
`define CES_MAP1_CNT_ONE     8'h01
`define CES_MAP1_CNT_TWO     8'h02
`define CES_MAP1_E1_RST      32'h60100010
`define CES_MAP1_E2_RST      32'h60200010
`define CES_MAP2_CNT_RST     8'h00
`define CES_MAP2_E1_RST      32'h64010110
`define CES_MAP2_E2_RST      32'h64010210
`define CES_MAP2_E3_RST      32'h64010310
`define CES_ZERO32           32'h00000000
`define CES_START_PREOP      32'h00000004
`define CES_START_OP         32'h00000000
`define CES_ERR_GEN          0
`define CES_ERR_CUR          1
`define CES_ERR_VOLT         2
`define CES_ERR_TEMP         3
`define CES_ERR_COMM         4
`define CES_ERR_PROF         5
`define CES_ERR_RSVD         6
`define CES_ERR_MFR          7
`define CES_VF_PWR_NOW       6
`define CES_VF_PWR_MEM       7
`define CES_VF_USED          13
`define CES_ABORT_NOOBJ      32'h06020000
`define CES_ABORT_RO         32'h06010002
`define CES_ABORT_NOSUB      32'h06090011
`endif

// *** include/ces_pkg.sv ***
// types shared by the object dictionary files
// assumes ces_defs.svh is on the include path
`include "ces_defs.svh"
package ces_pkg;
    typedef enum logic [1:0] {
        CES_NMT_BOOT  = 2'b00,
        CES_NMT_PREOP = 2'b01,
        CES_NMT_OP    = 2'b10
    } ces_nmt_t;
    typedef logic [31:0] ces_word_t;
endpackage : ces_pkg

// *** rtl/ces_map_table.sv ***
// one tpdo mapping table: count byte and four 32-bit entries
// assumes writes come from the object decoder in the same clock
`timescale 1ns/1ps
`include "ces_defs.svh"
module ces_map_table #(
    parameter logic [7:0]  CNT_RST = 8'h00,
    parameter logic [31:0] E1_RST  = 32'h00000000,
    parameter logic [31:0] E2_RST  = 32'h00000000,
    parameter logic [31:0] E3_RST  = 32'h00000000
) (
    input  wire logic              clk,      // device clock
    input  wire logic              reset_n,  // async reset, low
    input  wire logic              wr_en,    // write strobe
    input  wire logic [7:0]        wr_sub,   // subindex
    input  wire ces_pkg::ces_word_t wr_data, // write data
    input  wire logic [7:0]        rd_sub,   // read subindex
    output logic [31:0]            rd_data   // registered read data
);
    import ces_pkg::*;
    logic [7:0]  cnt_q,  cnt_d;
    logic [31:0] ent_q [1:`CES_MAP_ENTRIES];
    logic [31:0] ent_d [1:`CES_MAP_ENTRIES];
    logic [31:0] rd_d;
    ////////////////////////////////////////////////////////////////
    // next values of table and read data
    always_comb begin
        cnt_d = cnt_q;
        ent_d = ent_q;
        rd_d  = `CES_ZERO32;
        if (wr_en && wr_sub == `CES_SUB_COUNT) cnt_d = wr_data[7:0];
        for (int i = 1; i <= `CES_MAP_ENTRIES; i++) begin
            // entry is index[31:16] sub[15:8] length[7:0]
            if (wr_en && wr_sub == 8'(i)) ent_d[i] = wr_data;
            if (rd_sub == 8'(i)) rd_d = ent_q[i];
        end
        if (rd_sub == `CES_SUB_COUNT) rd_d = {24'h000000, cnt_q};
    end
    // registers, defaults
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q    <= CNT_RST;
            ent_q[1] <= E1_RST;
            ent_q[2] <= E2_RST;
            ent_q[3] <= E3_RST;
            ent_q[4] <= `CES_ZERO32;
            rd_data  <= `CES_ZERO32;
        end else begin
            cnt_q   <= cnt_d;
            ent_q   <= ent_d;
            rd_data <= rd_d;
        end
    end
endmodule : ces_map_table

// *** verification/ces_master_model.sv ***
// stand-in for the network master: issues object accesses one at a time
// assumes the object decoder answers on obj_ack within a few cycles
`timescale 1ns/1ps
module ces_master_model (
    input  wire logic          clk,        // device clock
    output logic               obj_valid,  // access strobe
    output logic               obj_write,  // 1 write, 0 read
    output logic [15:0]        obj_index,  // object index
    output logic [7:0]         obj_sub,    // subindex
    output ces_pkg::ces_word_t obj_wdata,  // write data
    input  wire logic          obj_ack     // answer pulse
);
    import ces_pkg::*;
    // idle levels at time zero
    initial begin
        obj_valid = 1'b0;
        obj_write = 1'b0;
        obj_index = 16'h0000;
        obj_sub   = 8'h00;
        obj_wdata = 32'h00000000;
    end
    // one strobe, then lines show the inverse so stale values are never trusted
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input ces_word_t wd);
        int n;
        @(posedge clk);
        obj_valid <= 1'b1;
        obj_write <= wr;
        obj_index <= idx;
        obj_sub   <= sub;
        obj_wdata <= wd; // whole word
        @(posedge clk);
        obj_valid <= 1'b0;
        obj_write <= ~wr;
        obj_index <= ~idx;
        obj_sub   <= ~sub;
        obj_wdata <= ~wd;
        n = 0;
        #1;
        // bounded wait for the answer; map reads take one cycle more
        while (obj_ack !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : access
endmodule : ces_master_model

// *** verification/canopen_error_status_pdo_map_tb_top.sv ***
// self-checking bench for the object dictionary registers
// assumes ces_od_regs and ces_master_model are compiled first
`timescale 1ns/1ps
module canopen_error_status_pdo_map_tb_top;
    import ces_pkg::*;
    typedef struct packed {logic ab; logic chk; logic st; ces_word_t d;} ces_exp_t;
    logic      clk = 1'b0, reset_n = 1'b0, dual_axis = 1'b0, boot_done = 1'b0;
    logic      obj_valid, obj_write, obj_ack, obj_abort, store_req;
    logic [15:0] obj_index, evt2_time;
    logic [7:0]  obj_sub, err_reg;
    ces_word_t obj_wdata, obj_rdata, vendor_word, rnd, vexp;
    ces_nmt_t  nmt_state;
    logic [5:1] err_class = 5'h00;
    logic [1:0] tilt_cross = 2'h0, tilt_range = 2'h0;
    logic       temp_low = 1'b0, temp_high = 1'b0, power_fault = 1'b0, latch = 1'b0;
    logic [4:0] mem_faults = 5'h00;
    logic [16:0] s;
    ces_exp_t   e;
    ces_exp_t   expq[$];
    int         n_errors = 0, comparisons = 0;
    ces_word_t  m1 [5] = '{32'h01, 32'h60100010, 32'h60200010, 32'h0, 32'h0};
    ces_word_t  m2 [5] = '{32'h00, 32'h64010110, 32'h64010210, 32'h64010310, 32'h0};
    ////////////////////////////////////////////////////////////////////////////
    // clock, design and master
    always #2 clk = ~clk;
    ces_od_regs u_ces_od_regs (.clk(clk), .reset_n(reset_n), .dual_axis(dual_axis), .boot_done(boot_done),
        .obj_valid(obj_valid), .obj_write(obj_write), .obj_index(obj_index), .obj_sub(obj_sub),
        .obj_wdata(obj_wdata), .err_class(err_class), .tilt_cross(tilt_cross), .tilt_range(tilt_range),
        .temp_low(temp_low), .temp_high(temp_high), .power_fault(power_fault), .mem_faults(mem_faults),
        .obj_ack(obj_ack), .obj_abort(obj_abort), .obj_rdata(obj_rdata), .store_req(store_req),
        .err_reg(err_reg), .vendor_word(vendor_word), .evt2_time(evt2_time), .nmt_state(nmt_state));
    ces_master_model u_ces_master_model (.clk(clk), .obj_valid(obj_valid), .obj_write(obj_write),
        .obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata), .obj_ack(obj_ack));
    ////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic report_and_stop;
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    // direct compare of a settled output
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // note the expected answer, then let the master issue the access
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input ces_word_t wd,
                        input logic ab, input logic chk, input ces_word_t ed, input logic st = 1'b0);
        expq.push_back('{ab, chk, st, ed});
        u_ces_master_model.access(wr, idx, sub, wd);
    endtask : xfer
    // answer monitor, sampled mid-cycle where registered outputs are settled
    always @(negedge clk) begin
        if (obj_ack === 1'b1) begin
            if (expq.size() == 0) begin
                n_errors++;
                $display("Error at %0t: answer without request", $time);
            end else begin
                e = expq.pop_front();
                comparisons++;
                if (obj_abort !== e.ab || store_req !== e.st || (e.chk && obj_rdata !== e.d)) begin
                    n_errors++;
                    $display("Error at %0t: answer %h abort %b store %b", $time, obj_rdata, obj_abort, store_req);
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // reset with variant strap, boot pulse, status drive
    task automatic do_reset(input logic dual);
        @(posedge clk);
        reset_n   <= 1'b0;
        dual_axis <= dual;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        latch = 1'b0;
    endtask : do_reset
    task automatic boot;
        @(posedge clk);
        boot_done <= 1'b1;
        @(posedge clk);
        boot_done <= 1'b0;
        @(posedge clk);
        #1;
    endtask : boot
    // s: class[5:1], mem[4:0], power, temp high, temp low, range[1:0], cross[1:0]
    task automatic status(input logic [16:0] v, input logic chk_err);
        @(posedge clk);
        {err_class, mem_faults, power_fault, temp_high, temp_low, tilt_range, tilt_cross} <= v;
        latch = latch | v[6];
        vexp = {19'h0, v[11:7], latch, v[6:0]};
        repeat (2) @(posedge clk);
        #1;
        check(vendor_word, vexp);
        if (chk_err) begin
            check({24'h0, err_reg}, {24'h0, |vexp, 1'b0, v[16:12], |{vexp, v[16:12]}});
        end
    endtask : status
    ////////////////////////////////////////////////////////////////////////////
    // watchdog over the whole run
    initial begin
        #80000;
        n_errors++;
        $display("Error at %0t: run did not finish", $time);
        report_and_stop();
    end
    // main sequence
    initial begin
        void'($urandom(2));
        do_reset(1'b0);
        #1;
        check({16'h0, evt2_time}, 32'h00000064);
        check({30'h0, nmt_state}, {30'h0, CES_NMT_BOOT});
        xfer(1'b0, 16'h1801, 8'h05, 32'h0, 1'b0, 1'b1, 32'h00000064);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, 16'h1a00, 8'(i), 32'h0, 1'b0, 1'b1, m1[i]);
            xfer(1'b0, 16'h1a01, 8'(i), 32'h0, 1'b0, 1'b1, m2[i]);
        end
        xfer(1'b0, 16'h1f80, 8'h00, 32'h0, 1'b0, 1'b1, 32'h00000000);
        rnd = $urandom();
        xfer(1'b1, 16'h1a01, 8'h01, rnd, 1'b0, 1'b0, 32'h0);
        xfer(1'b0, 16'h1a01, 8'h01, 32'h0, 1'b0, 1'b1, rnd);
        xfer(1'b1, 16'h1801, 8'h05, rnd, 1'b0, 1'b0, 32'h0);
        check({16'h0, evt2_time}, {16'h0, rnd[15:0]});
        xfer(1'b0, 16'h1801, 8'h05, 32'h0, 1'b0, 1'b1, {16'h0, rnd[15:0]});
        xfer(1'b1, 16'h1010, 8'h01, 32'h65766173, 1'b0, 1'b0, 32'h0, 1'b1);
        xfer(1'b0, 16'h2000, 8'h00, 32'h0, 1'b1, 1'b1, 32'h06020000);
        xfer(1'b1, 16'h2000, 8'h00, rnd, 1'b1, 1'b1, 32'h06010002);
        xfer(1'b1, 16'h1001, 8'h00, rnd, 1'b1, 1'b0, 32'h0);
        xfer(1'b0, 16'h1010, 8'h01, 32'h0, 1'b1, 1'b0, 32'h0);
        xfer(1'b0, 16'h1a00, 8'h08, 32'h0, 1'b1, 1'b0, 32'h0);
        xfer(1'b0, 16'h1001, 8'h00, 32'h0, 1'b0, 1'b1, 32'h0);
        xfer(1'b1, 16'h1f80, 8'h00, 32'h00000004, 1'b0, 1'b0, 32'h0);
        boot();
        check({30'h0, nmt_state}, {30'h0, CES_NMT_PREOP});
        for (int i = 0; i < 24; i++) begin
            s = 17'($urandom()) & 17'h1ffbf;
            status(s, 1'b1);
        end
        status(17'h1ffbf, 1'b1);
        status(17'h00040, 1'b1);
        xfer(1'b0, 16'h1002, 8'h00, 32'h0, 1'b0, 1'b1, vexp);
        status(17'h00000, 1'b0);
        do_reset(1'b1);
        #1;
        check(vendor_word, 32'h0);
        check({16'h0, evt2_time}, 32'h00000064);
        xfer(1'b0, 16'h1a01, 8'h01, 32'h0, 1'b0, 1'b1, 32'h64010110);
        boot();
        check({30'h0, nmt_state}, {30'h0, CES_NMT_OP});
        xfer(1'b0, 16'h1a00, 8'h00, 32'h0, 1'b0, 1'b1, 32'h00000002);
        repeat (4) @(posedge clk);
        check(32'(expq.size()), 32'h0);
        report_and_stop();
    end
endmodule : canopen_error_status_pdo_map_tb_top
